// [core/pmsq_core.sv]
// Measurement sequencer: power modes, conversion order, filtering, registers.
// Assumes a converter that answers each start with one done pulse and data.
//
// The AXI4-Lite interface to the registers was left to the implementer.
module pmsq_core
  import pmsq_pkg::*;
#(
  parameter int unsigned P_SB_CYC0 = pmsq_pkg::sb_cycles(pmsq_pkg::SB_MS0),
  parameter int unsigned P_SB_CYC1 = pmsq_pkg::sb_cycles(pmsq_pkg::SB_MS1),
  parameter int unsigned P_SB_CYC2 = pmsq_pkg::sb_cycles(pmsq_pkg::SB_MS2),
  parameter int unsigned P_SB_CYC3 = pmsq_pkg::sb_cycles(pmsq_pkg::SB_MS3),
  parameter int unsigned P_SB_CYC4 = pmsq_pkg::sb_cycles(pmsq_pkg::SB_MS4),
  parameter int unsigned P_SB_CYC5 = pmsq_pkg::sb_cycles(pmsq_pkg::SB_MS5),
  parameter int unsigned P_SB_CYC6 = pmsq_pkg::sb_cycles(pmsq_pkg::SB_MS6),
  parameter int unsigned P_SB_CYC7 = pmsq_pkg::sb_cycles(pmsq_pkg::SB_MS7)
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [pmsq_pkg::AXI_AW-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [pmsq_pkg::AXI_AW-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_conv_start,
  output logic o_conv_press,
  output logic [2:0] o_conv_osr,
  input wire logic i_conv_done,
  input wire logic [19:0] i_conv_data
);
  import pmsq_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  pmsq_state_t state_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [AXI_AW-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_cfg;
  logic [7:0] rd_val;
  logic [1:0] mode_q;
  logic pend_q;
  logic [1:0] pend_mode_q;
  logic [2:0] osrt_q;
  logic [2:0] osrp_q;
  logic [2:0] filt_q;
  logic [2:0] sb_q;
  logic [2:0] lat_t_q;
  logic [2:0] lat_p_q;
  logic busy_q;
  logic [19:0] raw_t_q;
  logic [19:0] raw_p_q;
  logic [19:0] temp_q;
  logic [19:0] pres_q;
  logic [19:0] filt_t;
  logic [19:0] filt_p;
  logic measuring;
  logic mode_forced;
  logic [1:0] next_mode;
  logic sb_load;
  logic sb_abort;
  logic sb_done;
  logic [31:0] sb_count;

  function automatic logic addr_ok(input logic [AXI_AW-1:0] a);
    addr_ok = (a[AXI_AW-1:10] == 2'h0) && (a[9:2] >= IDX_STATUS) && (a[9:2] <= IDX_T_XB)
      && (a[9:2] != 8'hF6);
  endfunction

  assign measuring = (state_q != ST_IDLE) && (state_q != ST_STANDBY);
  assign mode_forced = (mode_q != MODE_SLEEP) && (mode_q != MODE_NORMAL);
  assign next_mode = pend_q ? pend_mode_q : mode_q;

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign wr_fire = aw_hold_q && w_hold_q && !o_bvalid;
  assign wr_ctrl = wr_fire && w_strb_q && (aw_addr_q[9:2] == IDX_CTRL) && addr_ok(aw_addr_q);
  assign wr_cfg = wr_fire && w_strb_q && (aw_addr_q[9:2] == IDX_CFG) && addr_ok(aw_addr_q);

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        o_awready <= 1'b0;
        aw_hold_q <= 1'b1;
        aw_addr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready)
      begin
        o_wready <= 1'b0;
        w_hold_q <= 1'b1;
        w_data_q <= i_wdata[7:0];
        w_strb_q <= i_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= addr_ok(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (o_bvalid && i_bready)
      begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always_comb
  begin
    case (i_araddr[9:2])
      IDX_STATUS: rd_val = 8'(measuring) << STAT_MEAS_BIT;
      IDX_CTRL: rd_val = {osrt_q, osrp_q, mode_q};
      IDX_CFG: rd_val = {sb_q, filt_q, 2'h0};
      IDX_P_MSB: rd_val = pres_q[19:12];
      IDX_P_LSB: rd_val = pres_q[11:4];
      IDX_P_XB: rd_val = {pres_q[3:0], 4'h0};
      IDX_T_MSB: rd_val = temp_q[19:12];
      IDX_T_LSB: rd_val = temp_q[11:4];
      IDX_T_XB: rd_val = {temp_q[3:0], 4'h0};
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= RESP_OKAY;
    end
    else if (i_arvalid && o_arready)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= addr_ok(i_araddr) ? {24'h0, rd_val} : 32'h0;
      o_rresp <= addr_ok(i_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // ****************************************
  // Configuration and mode control
  // ****************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      osrt_q <= CTRL_RST[CTRL_OSRT_LSB +: 3];
      osrp_q <= CTRL_RST[CTRL_OSRP_LSB +: 3];
      filt_q <= CFG_RST[CFG_FILT_LSB +: 3];
      sb_q <= CFG_RST[CFG_SB_LSB +: 3];
    end
    else
    begin
      if (wr_ctrl)
      begin
        osrt_q <= w_data_q[CTRL_OSRT_LSB +: 3];
        osrp_q <= w_data_q[CTRL_OSRP_LSB +: 3];
      end
      if (wr_cfg)
      begin
        filt_q <= w_data_q[CFG_FILT_LSB +: 3];
        sb_q <= w_data_q[CFG_SB_LSB +: 3];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mode_q <= MODE_SLEEP;
      pend_q <= 1'b0;
      pend_mode_q <= MODE_SLEEP;
    end
    else
    begin
      if (state_q == ST_PUBLISH)
      begin
        if (pend_q)
        begin
          mode_q <= pend_mode_q;
          pend_q <= 1'b0;
        end
        else if (mode_forced)
          mode_q <= MODE_SLEEP;
      end
      else if (pend_q && !measuring)
      begin
        mode_q <= pend_mode_q;
        pend_q <= 1'b0;
      end
      // A write landing on the publish edge is kept as the pending change unless one is already pending
      if (wr_ctrl && !pend_q)
      begin
        if (measuring)
        begin
          pend_q <= 1'b1;
          pend_mode_q <= w_data_q[CTRL_MODE_LSB +: 2];
        end
        else
          mode_q <= w_data_q[CTRL_MODE_LSB +: 2];
      end
    end
  end

  // ****************************************
  // Measurement sequencer
  // ****************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      lat_t_q <= 3'h0;
      lat_p_q <= 3'h0;
      raw_t_q <= 20'h0;
      raw_p_q <= 20'h0;
      o_conv_start <= 1'b0;
      o_conv_press <= 1'b0;
      o_conv_osr <= 3'h0;
    end
    else
    begin
      o_conv_start <= 1'b0;
      case (state_q)
        ST_IDLE:
          if (mode_q != MODE_SLEEP && !pend_q)
          begin
            lat_t_q <= osrt_q;
            lat_p_q <= osrp_q;
            state_q <= ST_TCONV;
          end
        ST_TCONV:
          if (lat_t_q == 3'h0)
            state_q <= ST_PCONV;
          else if (!busy_q)
          begin
            busy_q <= 1'b1;
            o_conv_start <= 1'b1;
            o_conv_press <= 1'b0;
            o_conv_osr <= lat_t_q;
          end
          else if (i_conv_done)
          begin
            busy_q <= 1'b0;
            raw_t_q <= i_conv_data & osr_mask(lat_t_q);
            state_q <= ST_PCONV;
          end
        ST_PCONV:
          if (lat_p_q == 3'h0)
            state_q <= ST_FILT;
          else if (!busy_q)
          begin
            busy_q <= 1'b1;
            o_conv_start <= 1'b1;
            o_conv_press <= 1'b1;
            o_conv_osr <= lat_p_q;
          end
          else if (i_conv_done)
          begin
            busy_q <= 1'b0;
            raw_p_q <= i_conv_data & osr_mask(lat_p_q);
            state_q <= ST_FILT;
          end
        ST_FILT:
          state_q <= ST_PUBLISH;
        ST_PUBLISH:
          state_q <= (next_mode == MODE_NORMAL) ? ST_STANDBY : ST_IDLE;
        ST_STANDBY:
          if (mode_q != MODE_NORMAL)
            state_q <= ST_IDLE;
          else if (sb_done)
          begin
            lat_t_q <= osrt_q;
            lat_p_q <= osrp_q;
            state_q <= ST_TCONV;
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Filters and result registers
  // ****************************************
  pmsq_filter u_filt_t
  (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_clear(wr_cfg),
    .i_load((state_q == ST_FILT) && (lat_t_q != 3'h0)),
    .i_shift(filt_shift(filt_q)),
    .i_sample(raw_t_q),
    .o_value(filt_t)
  );

  pmsq_filter u_filt_p
  (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_clear(wr_cfg),
    .i_load((state_q == ST_FILT) && (lat_p_q != 3'h0)),
    .i_shift(filt_shift(filt_q)),
    .i_sample(raw_p_q),
    .o_value(filt_p)
  );

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      temp_q <= SKIP_VAL;
      pres_q <= SKIP_VAL;
    end
    else if (state_q == ST_PUBLISH)
    begin
      temp_q <= (lat_t_q == 3'h0) ? SKIP_VAL : filt_t;
      pres_q <= (lat_p_q == 3'h0) ? SKIP_VAL : filt_p;
    end
  end

  // Standby length chosen when the period starts; later writes apply next time
  always_comb
  begin
    case (sb_q)
      3'h0: sb_count = P_SB_CYC0;
      3'h1: sb_count = P_SB_CYC1;
      3'h2: sb_count = P_SB_CYC2;
      3'h3: sb_count = P_SB_CYC3;
      3'h4: sb_count = P_SB_CYC4;
      3'h5: sb_count = P_SB_CYC5;
      3'h6: sb_count = P_SB_CYC6;
      default: sb_count = P_SB_CYC7;
    endcase
  end

  assign sb_load = (state_q == ST_PUBLISH) && (next_mode == MODE_NORMAL);
  assign sb_abort = (state_q == ST_STANDBY) && (mode_q != MODE_NORMAL);

  pmsq_timer u_standby
  (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_load(sb_load),
    .i_abort(sb_abort),
    .i_count(sb_count),
    .o_done(sb_done)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  AST_SLEEP_NO_CONV: assert property ((state_q == ST_IDLE && mode_q == MODE_SLEEP)
    |=> !o_conv_start) else $error("conversion in sleep");
  AST_DATA_ONLY_AT_END: assert property ((state_q != ST_PUBLISH)
    |=> ($stable(pres_q) && $stable(temp_q))) else $error("result moved mid period");
  AST_FORCED_BACK: assert property ((state_q == ST_PUBLISH && mode_forced && !pend_q)
    |=> (mode_q == MODE_SLEEP && state_q == ST_IDLE)) else $error("forced not back to sleep");
  AST_NORMAL_LOOP: assert property ((state_q == ST_PUBLISH && next_mode == MODE_NORMAL)
    |=> state_q == ST_STANDBY ##1 state_q == ST_STANDBY) else $error("normal loop broken");
  AST_P_SKIP: assert property ((state_q == ST_PUBLISH && lat_p_q == 3'h0)
    |=> pres_q == SKIP_VAL) else $error("skipped pressure not 0x80000");
  AST_T_WIDTH: assert property ((state_q == ST_PUBLISH && lat_t_q == 3'h1
    && filt_q == 3'h0) |=> temp_q[3:0] == 4'h0) else $error("x1 temperature too wide");
  AST_T_THEN_P: assert property ((state_q == ST_TCONV && busy_q && i_conv_done)
    |=> state_q == ST_PCONV ##1 (lat_p_q == 3'h0 || (o_conv_start && o_conv_press)))
    else $error("order broken");
  AST_DEFER: assert property ((measuring && state_q != ST_PUBLISH && wr_ctrl)
    |=> $stable(mode_q)) else $error("mode changed mid measurement");

  COV_FORCED: cover property (state_q == ST_PUBLISH && mode_forced);
  COV_STANDBY_WAKE: cover property (state_q == ST_STANDBY && sb_done);
  COV_PENDING: cover property (wr_ctrl && pend_q);
endmodule

// [core/pmsq_filter.sv]
// One channel of the IIR low-pass filter with its own memory.
// Assumes loads come from the sequencer once per measurement period.
module pmsq_filter
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_clear,
  input wire logic i_load,
  input wire logic [2:0] i_shift,
  input wire logic [19:0] i_sample,
  output logic [19:0] o_value
);
  logic primed_q;
  logic [24:0] acc;
  logic [24:0] sum;

  // Widened so old * (c - 1) + new never wraps at c = 16
  always_comb
  begin
    acc = {5'h0, o_value} << i_shift;
    sum = acc - {5'h0, o_value} + {5'h0, i_sample};
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      primed_q <= 1'b0;
      o_value <= 20'h0;
    end
    else if (i_load)
    begin
      primed_q <= 1'b1;
      if (i_clear || !primed_q)
        o_value <= i_sample;
      else
        o_value <= 20'(sum >> i_shift);
    end
    else if (i_clear)
      primed_q <= 1'b0;
  end

  AST_FILT_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_clear && !i_load) |=> !primed_q) else $error("filter not reset");
  AST_FILT_FIRST: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_load && (i_clear || !primed_q)) |=> (o_value == $past(i_sample)))
    else $error("first pass");
  AST_FILT_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    !i_load |=> $stable(o_value)) else $error("filter memory moved");
endmodule

// [core/pmsq_timer.sv]
// Standby period down-counter for the measurement sequencer.
// Assumes the load value is at least one cycle.
module pmsq_timer
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_load,
  input wire logic i_abort,
  input wire logic [31:0] i_count,
  output logic o_done
);
  logic [31:0] cnt_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_q <= 32'h0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_abort)
        cnt_q <= 32'h0;
      else if (i_load)
        cnt_q <= i_count;
      else if (cnt_q != 32'h0)
      begin
        cnt_q <= cnt_q - 32'h1;
        o_done <= (cnt_q == 32'h1);
      end
    end
  end

  AST_TIMER_RUNS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_load && !i_abort && i_count > 32'h1) |=> !o_done) else $error("timer ended early");
endmodule

// [inc/pmsq_pkg.sv]
// Constants, types and helpers shared by the measurement sequencer files.
// Assumes a 200 MHz system clock and an AXI4-Lite register port.
// Functional notes
// - Sleep mode starts no conversion and leaves result registers unchanged.
// - Normal mode loops measurement then standby until another mode is chosen.
// - Forced mode does one measurement, then returns itself to sleep.
// - Reset clears control logic and control registers, sets results to 0x80000; device then sits in sleep.
// - A measurement is temperature conversion, pressure conversion, then filtering.
// - Pressure and temperature oversampling are set independently, skip up to x16.
// - Pressure oversampling field enables or skips; extra bits read at 0xF9.
// - Pressure width 16 to 20 bits by oversampling; skipped reads 0x80000.
// - Temperature oversampling field enables or skips; extra bits read at 0xFC.
// - Temperature code 000 skips, 001..100 x1..x8, 101..111 x16.
// - Filter output is (old times (c minus 1) plus new) divided by c.
// - Filter code 000 off, 001 c2, 010 c4, 011 c8, higher c16.
// - Any write to the filter field resets filter state.
// - First sample after filter reset passes unchanged and becomes memory.
// - A skipped channel keeps its filter memory while reading 0x80000.
// - Re-enabled channel filters against memory from its last real conversion.
// - Mode code 00 sleep, 01 and 10 forced, 11 normal.
// - Standby code selects 0.5, 62.5, 125, 250, 500, 1000, 2000, 4000 ms.
// - Mode write during measurement waits for its end; later writes ignored.
package pmsq_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam real CLK_PERIOD_NS = 5.0;
  localparam real SB_MS0 = 0.5;
  localparam real SB_MS1 = 62.5;
  localparam real SB_MS2 = 125.0;
  localparam real SB_MS3 = 250.0;
  localparam real SB_MS4 = 500.0;
  localparam real SB_MS5 = 1000.0;
  localparam real SB_MS6 = 2000.0;
  localparam real SB_MS7 = 4000.0;
  // ****************************************
  // Register map: indices, byte address is four times the index
  // ****************************************
  localparam int AXI_AW = 12;
  localparam logic [7:0] IDX_STATUS = 8'hF3;
  localparam logic [7:0] IDX_CTRL = 8'hF4;
  localparam logic [7:0] IDX_CFG = 8'hF5;
  localparam logic [7:0] IDX_P_MSB = 8'hF7;
  localparam logic [7:0] IDX_P_LSB = 8'hF8;
  localparam logic [7:0] IDX_P_XB = 8'hF9;
  localparam logic [7:0] IDX_T_MSB = 8'hFA;
  localparam logic [7:0] IDX_T_LSB = 8'hFB;
  localparam logic [7:0] IDX_T_XB = 8'hFC;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_OSRP_LSB = 2;
  localparam int CTRL_OSRT_LSB = 5;
  localparam int CFG_FILT_LSB = 2;
  localparam int CFG_SB_LSB = 5;
  localparam int STAT_MEAS_BIT = 3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [19:0] SKIP_VAL = 20'h80000;
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Types and helpers
  // ****************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_TCONV = 6'h02,
    ST_PCONV = 6'h04,
    ST_FILT = 6'h08,
    ST_PUBLISH = 6'h10,
    ST_STANDBY = 6'h20
  } pmsq_state_t;

  function automatic int unsigned sb_cycles(input real ms);
    sb_cycles = $rtoi(ms * 1.0e6 / CLK_PERIOD_NS);
  endfunction

  // Keeps 15 + n result bits for oversampling code n from 1 up, n capped at 5
  function automatic logic [19:0] osr_mask(input logic [2:0] code);
    case (code)
      3'h1: osr_mask = 20'hFFFF0;
      3'h2: osr_mask = 20'hFFFF8;
      3'h3: osr_mask = 20'hFFFFC;
      3'h4: osr_mask = 20'hFFFFE;
      default: osr_mask = 20'hFFFFF;
    endcase
  endfunction

  function automatic logic [2:0] filt_shift(input logic [2:0] code);
    filt_shift = (code > 3'h4) ? 3'h4 : code;
  endfunction
endpackage

// [tb/pmsq_conv_model.sv]
// Behavioural converter answering each start of the sequencer.
// Assumes the bench supplies the raw temperature and pressure values.
module pmsq_conv_model
#(
  parameter int DLY = 3
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_conv_start,
  input wire logic i_conv_press,
  input wire logic [19:0] i_t_val,
  input wire logic [19:0] i_p_val,
  output logic o_conv_done,
  output logic [19:0] o_conv_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt <= 0;
      o_conv_done <= 1'b0;
      o_conv_data <= 20'h0;
    end
    else
    begin
      o_conv_done <= 1'b0;
      // Data is only valid with done; otherwise it inverts every cycle to expose misuse
      o_conv_data <= ~o_conv_data;
      if (i_conv_start)
        cnt <= DLY;
      else if (cnt == 1)
      begin
        o_conv_done <= 1'b1;
        o_conv_data <= i_conv_press ? i_p_val : i_t_val;
        cnt <= 0;
      end
      else if (cnt > 1)
        cnt <= cnt - 1;
    end
  end
endmodule

// [tb/pressure_measurement_sequencer_tb_top.sv]
// Self-checking bench of the measurement sequencer over AXI4-Lite.
// Assumes the converter model stands on the conversion port.
module pressure_measurement_sequencer_tb_top;
  import pmsq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, cstart, cpress, cdone;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] cosr;
  logic [19:0] cdata, tv = 20'h0, pv = 20'h0;
  int n_mismatch = 0, n_checks = 0, nst = 0, cyc = 0, tlast = 0, tgap = 0;
  logic [2:0] prot = 3'h0;
  logic [3:0] wstrb = 4'hF, losr = 4'h0;
  always #2.5 clk = ~clk;
  // Logs each start: count, last kind and code, spacing of temperature starts
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cstart === 1'b1)
    begin
      nst <= nst + 1;
      losr <= {cpress, cosr};
      if (cpress === 1'b0)
      begin
        tgap <= cyc - tlast;
        tlast <= cyc;
      end
    end
  end
  // Only the standby code in use is shortened; the others keep their long defaults
  pmsq_core #(.P_SB_CYC0(20)) dut (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_awvalid(awvalid), .o_awready(awready),
    .i_awaddr(awaddr), .i_awprot(prot), .i_wvalid(wvalid), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .i_arprot(prot), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp), .o_conv_start(cstart), .o_conv_press(cpress), .o_conv_osr(cosr),
    .i_conv_done(cdone), .i_conv_data(cdata));
  pmsq_conv_model conv (.i_sys_clk(clk), .i_rst_b(rst_b), .i_conv_start(cstart),
    .i_conv_press(cpress), .i_t_val(tv), .i_p_val(pv), .o_conv_done(cdone),
    .o_conv_data(cdata));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tmo();
    n_mismatch++;
    conclude();
  endtask
  // Ready is registered, so its level at the falling edge is what the next rising edge sees
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] rsp);
    int n;
    logic ta, tw, a, w;
    a = 0;
    w = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, d};
    bready <= 1'b1;
    for (n = 0; n < 200 && !(a && w); n++)
    begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      a = a | ta;
      w = w | tw;
    end
    if (!(a && w))
      tmo();
    for (n = 0; n < 200; n++)
    begin
      @(negedge clk);
      if (bvalid === 1'b1)
        break;
    end
    if (n == 200)
      tmo();
    rsp = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] rsp);
    int n;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= {2'b00, idx, 2'b00};
    rready <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(negedge clk);
      if (arready === 1'b1)
        break;
    end
    if (n == 200)
      tmo();
    @(posedge clk);
    arvalid <= 1'b0;
    for (n = 0; n < 200; n++)
    begin
      @(negedge clk);
      if (rvalid === 1'b1)
        break;
    end
    if (n == 200)
      tmo();
    d = rdata[7:0];
    rsp = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(what, exp, d);
    chk({what, " rresp"}, {6'h0, RESP_OKAY}, {6'h0, r});
  endtask
  // Writes the control byte, then polls until the mode field reads sleep again
  task automatic meas(input logic [7:0] ctrl);
    logic [7:0] d;
    logic [1:0] r;
    int n;
    wr(IDX_CTRL, ctrl, r);
    chk("ctrl bresp", {6'h0, RESP_OKAY}, {6'h0, r});
    for (n = 0; n < 300; n++)
    begin
      rd(IDX_CTRL, d, r);
      if (d[1:0] === MODE_SLEEP)
        break;
    end
    if (n == 300)
      tmo();
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic sc_reset();
    logic [7:0] d;
    logic [1:0] r;
    rchk("ctrl", IDX_CTRL, CTRL_RST);
    rchk("cfg", IDX_CFG, CFG_RST);
    rchk("p msb", IDX_P_MSB, 8'h80);
    rd(8'hF6, d, r);
    chk("unmapped resp", {6'h0, RESP_SLVERR}, {6'h0, r});
  endtask
  task automatic sc_forced();
    tv = 20'h12345;
    pv = 20'hABCDE;
    meas(8'h35);
    chk("last conv", 8'h0D, {4'h0, losr});
    rchk("t msb", IDX_T_MSB, 8'h12);
    rchk("t lsb", IDX_T_LSB, 8'h34);
    rchk("t xb", IDX_T_XB, 8'h00);
    rchk("p lsb", IDX_P_LSB, 8'hCD);
    rchk("p xb", IDX_P_XB, 8'hE0);
    meas(8'h22);
    rchk("p skip msb", IDX_P_MSB, 8'h80);
    rchk("p skip xb", IDX_P_XB, 8'h00);
  endtask
  task automatic sc_filter();
    logic [1:0] r;
    wr(IDX_CFG, 8'h04, r);
    tv = 20'h10000;
    meas(8'hA1);
    rchk("first filtered", IDX_T_MSB, 8'h10);
    tv = 20'h20000;
    meas(8'hA1);
    rchk("filtered c2", IDX_T_MSB, 8'h18);
    wstrb <= 4'hE;
    wr(IDX_CFG, 8'h00, r);
    wstrb <= 4'hF;
    rchk("cfg kept", IDX_CFG, 8'h04);
  endtask
  task automatic sc_normal();
    int n, base;
    logic [1:0] r;
    base = nst;
    wr(IDX_CTRL, 8'h27, r);
    for (n = 0; n < 3000 && nst < base + 4; n++)
      @(posedge clk);
    chk("normal repeats", 8'h1, {7'h0, nst >= base + 4});
    // 15 edges of conversions with the 3-cycle converter, then 20 of standby
    chk("period gap", 8'h23, 8'(tgap));
    meas(8'h24);
    base = nst;
    repeat (200) @(posedge clk);
    chk("sleep starts", 8'h0, 8'(nst - base));
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    fork
      begin
        sc_reset();
        sc_forced();
        sc_filter();
        sc_normal();
      end
      begin
        repeat (90000) @(posedge clk);
        tmo();
      end
    join_any
    conclude();
  end
endmodule
